// ==== hw/crf_cmp_if.sv ====
// Carrier between the flag top and its comparator.
// Assumes one clock domain; no timing inside.
`timescale 1ns/1ps
interface crf_compare_if #(parameter int W = 16);
  logic [W-1:0] opA;
  logic [W-1:0] opB;
  logic isSigned;
  crf_pkg::crf_flags_t flags;
  modport ctl (output opA, output opB, output isSigned, input flags);
  modport alu (input opA, input opB, input isSigned, output flags);
endinterface : crf_compare_if

// ==== hw/crf_comparator.sv ====
// Combinational six-way compare of two operands.
// Assumes caller registers the result when a compare executes.
`timescale 1ns/1ps
`include "crf_consts.svh"
module crf_comparator (
  // Operands in, flags out
  crf_compare_if.alu compareBus
);
  import crf_pkg::*;
  logic less;
  logic same;
  // Signedness picks the ordering; equality is width-exact
  always_comb begin
    if (compareBus.isSigned) begin
      less = $signed(compareBus.opA) < $signed(compareBus.opB);
    end else begin
      less = compareBus.opA < compareBus.opB;
    end
    same = compareBus.opA == compareBus.opB;
    compareBus.flags = '0;
    compareBus.flags[`CRF_BIT_LESS] = less; // see RL1
    compareBus.flags[`CRF_BIT_LE] = less | same; // see RL2
    compareBus.flags[`CRF_BIT_EQ] = same; // see RL3
    compareBus.flags[`CRF_BIT_GREATER] = ~less & ~same; // see RL4
    compareBus.flags[`CRF_BIT_GE] = ~less; // see RL5
    compareBus.flags[`CRF_BIT_NE] = ~same; // see RL6
  end
endmodule : crf_comparator

// ==== hw/crf_compare_flags.sv ====
// Compare-result flag block: six flags updated by a compare.
// Assumes a CPU pulses compareInstruction with operands valid, and
// software uses the plain register port with one-cycle strobes.
`timescale 1ns/1ps
`include "crf_consts.svh"

// Behaviour
// RL1 - Compare sets less-than flag when first operand below second, else clears.
// RL2 - Compare sets less-or-equal flag when first not above second, else clears.
// RL3 - Compare sets equal flag when both operands match, else clears.
// RL4 - Compare sets greater-than flag when first above second, else clears.
// RL5 - Compare sets greater-or-equal flag when first not below second.
// RL6 - Compare sets not-equal flag when operands differ, else clears.
// RL7 - Flag positions after the six compare flags are unused, read zero.
// RL8 - All six flags change together on a compare, hold otherwise.
module crf_compare_flags #(
  parameter int W = `CRF_DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // CPU compare execution
  input wire logic compareInstruction,
  input wire logic [W-1:0] firstOperand,
  input wire logic [W-1:0] secondOperand,
  // Register port
  input wire crf_pkg::crf_addr_t regAddr,
  input wire crf_pkg::crf_data_t regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output crf_pkg::crf_data_t regRdata,
  // Result flags
  output logic lessThanFlag,
  output logic lessOrEqualFlag,
  output logic equalFlag,
  output logic greaterThanFlag,
  output logic greaterOrEqualFlag,
  output logic notEqualFlag,
  // Interrupt
  output logic interrupt
);
  import crf_pkg::*;

  // Address match, used by write and read decode
  function automatic logic hit(input crf_addr_t a, input crf_addr_t off);
    hit = (a == off);
  endfunction : hit

  // Zero-extend a narrow field into a bus word
  function automatic crf_data_t widen(input logic [W-1:0] v);
    widen = crf_data_t'(v);
  endfunction : widen

  typedef struct packed {
    logic [W-1:0] opA;
    logic [W-1:0] opB;
    logic signedMode;
    crf_flags_t flags;
    crf_data_t rdata;
    logic [`CRF_EVT_CNT-1:0] mask;
    logic irq;
  } crf_top_state_t;

  crf_top_state_t state;
  crf_top_state_t next_state;

  crf_compare_if #(.W(W)) compareBus ();

  logic swGo;
  logic exec;
  logic [`CRF_EVT_CNT-1:0] evt;
  logic [`CRF_EVT_CNT-1:0] irqStatus;
  logic [`CRF_EVT_CNT-1:0] irqMask;
  logic irqLine;
  logic statRead;
  logic irqPending;

  // Software may start a compare on the held operand registers
  assign swGo = regWrite && hit(regAddr, `CRF_ADDR_CTRL) &&
                regWdata[`CRF_CTRL_GO];

  // A CPU compare and a software start act alike
  assign exec = compareInstruction | swGo;

  // CPU operands win when both sources fire in one cycle
  assign compareBus.opA = compareInstruction ? firstOperand : state.opA;
  assign compareBus.opB = compareInstruction ? secondOperand : state.opB;
  assign compareBus.isSigned = state.signedMode;

  crf_comparator u_crf_comparator (
    .compareBus(compareBus)
  );

  // Completion event for the interrupt path
  assign evt[`CRF_EVT_DONE] = exec;
  assign statRead = regRead && hit(regAddr, `CRF_ADDR_STAT);

  crf_irq_unit #(.N(`CRF_EVT_CNT)) u_irq (
    .clk(clk),
    .reset(reset),
    .eventIn(evt),
    .readClear(statRead),
    .mask(irqMask),
    .status(irqStatus),
    .irq(irqLine)
  );

  // Mask sits in the state struct; the irq unit reads it from there
  assign irqMask = state.mask;
  assign irqPending = |(irqStatus & irqMask);

  // Next-state: operand writes, mode, flag capture, read data
  always_comb begin
    next_state = state;
    if (regWrite) begin
      case (regAddr)
        `CRF_ADDR_OPA: begin
          next_state.opA = regWdata[W-1:0];
        end
        `CRF_ADDR_OPB: begin
          next_state.opB = regWdata[W-1:0];
        end
        `CRF_ADDR_CTRL: begin
          next_state.signedMode = regWdata[`CRF_CTRL_SIGNED];
        end
        `CRF_ADDR_MASK: begin
          next_state.mask = regWdata[`CRF_EVT_CNT-1:0];
        end
        default: begin
          next_state.opA = state.opA; // other offsets take no write
        end
      endcase
    end
    // All six flags load in one cycle, else hold
    if (exec) begin
      next_state.flags = compareBus.flags; // see RL8
    end
    // Interrupt re-timed here so the output leaves this struct
    next_state.irq = irqLine;
    // Read data stands only in the cycle after the strobe
    next_state.rdata = '0;
    if (regRead) begin
      case (regAddr)
        `CRF_ADDR_OPA: begin
          next_state.rdata = widen(state.opA);
        end
        `CRF_ADDR_OPB: begin
          next_state.rdata = widen(state.opB);
        end
        `CRF_ADDR_CTRL: begin
          next_state.rdata[`CRF_CTRL_SIGNED] = state.signedMode;
        end
        `CRF_ADDR_FLAGS: begin
          // Upper positions stay zero: no function behind them
          next_state.rdata[`CRF_FLAG_CNT-1:0] = state.flags; // see RL7
        end
        `CRF_ADDR_STAT: begin
          next_state.rdata[`CRF_EVT_CNT-1:0] = irqStatus;
        end
        `CRF_ADDR_MASK: begin
          next_state.rdata[`CRF_EVT_CNT-1:0] = irqMask;
        end
        default: begin
          next_state.rdata = '0; // unmapped reads as zero
        end
      endcase
    end
  end

  // Single register stage for this module's state struct; event status and irq flops sit in u_irq
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs taken straight from the state flops
  assign regRdata = state.rdata;
  assign interrupt = state.irq;
  assign lessThanFlag = state.flags[`CRF_BIT_LESS];
  assign lessOrEqualFlag = state.flags[`CRF_BIT_LE];
  assign equalFlag = state.flags[`CRF_BIT_EQ];
  assign greaterThanFlag = state.flags[`CRF_BIT_GREATER];
  assign greaterOrEqualFlag = state.flags[`CRF_BIT_GE];
  assign notEqualFlag = state.flags[`CRF_BIT_NE];

  // Checks: helper copies of the operands actually compared
  logic [W-1:0] chkA;
  logic [W-1:0] chkB;
  logic chkSigned;
  assign chkA = compareBus.opA;
  assign chkB = compareBus.opB;
  assign chkSigned = state.signedMode;

  sequence s_execUnsigned;
    exec && !chkSigned;
  endsequence

  sequence s_execSigned;
    exec && chkSigned;
  endsequence

  sequence s_idle;
    !exec;
  endsequence

  property p_lessThan;
    @(posedge clk) disable iff (reset)
      s_execUnsigned |=> lessThanFlag == ($past(chkA) < $past(chkB));
  endproperty
  a_lessThan: assert property (p_lessThan) // see RL1
    else $error("less-than flag wrong after compare");

  property p_lessOrEqual;
    @(posedge clk) disable iff (reset)
      s_execUnsigned |=> lessOrEqualFlag == ($past(chkA) <= $past(chkB));
  endproperty
  a_lessOrEqual: assert property (p_lessOrEqual) // see RL2
    else $error("less-or-equal flag wrong after compare");

  property p_equal;
    @(posedge clk) disable iff (reset)
      exec |=> equalFlag == ($past(chkA) == $past(chkB));
  endproperty
  a_equal: assert property (p_equal) // see RL3
    else $error("equal flag wrong after compare");

  property p_greaterThan;
    @(posedge clk) disable iff (reset)
      s_execUnsigned |=> greaterThanFlag == ($past(chkA) > $past(chkB));
  endproperty
  a_greaterThan: assert property (p_greaterThan) // see RL4
    else $error("greater-than flag wrong after compare");

  property p_greaterOrEqual;
    @(posedge clk) disable iff (reset)
      s_execSigned |=>
        greaterOrEqualFlag == ($signed($past(chkA)) >= $signed($past(chkB)));
  endproperty
  a_greaterOrEqual: assert property (p_greaterOrEqual) // see RL5
    else $error("greater-or-equal flag wrong after signed compare");

  property p_notEqual;
    @(posedge clk) disable iff (reset)
      exec |=> notEqualFlag != equalFlag && notEqualFlag == ($past(chkA) != $past(chkB));
  endproperty
  a_notEqual: assert property (p_notEqual) // see RL6
    else $error("not-equal flag wrong after compare");

  property p_reservedZero;
    @(posedge clk) disable iff (reset)
      regRead && hit(regAddr, `CRF_ADDR_FLAGS) |=>
        regRdata[`CRF_DATA_W-1:`CRF_FLAG_CNT] == '0 &&
        regRdata[`CRF_FLAG_CNT-1:0] == $past(state.flags);
  endproperty
  a_reservedZero: assert property (p_reservedZero) // see RL7
    else $error("flag word shows bits above the compare group");

  property p_holdIdle;
    @(posedge clk) disable iff (reset)
      s_idle |=> $stable(state.flags);
  endproperty
  a_holdIdle: assert property (p_holdIdle) // see RL8
    else $error("flags moved with no compare");

  property p_consistent;
    @(posedge clk) disable iff (reset)
      exec ##1 1'b1 |-> lessOrEqualFlag == (lessThanFlag | equalFlag) &&
        greaterOrEqualFlag == !lessThanFlag &&
        greaterThanFlag == !lessOrEqualFlag;
  endproperty
  a_consistent: assert property (p_consistent) // see RL8
    else $error("compare flags disagree with each other");

  // Status, irq and output flop: interrupt two edges after the exec edge
  property p_irqFollows;
    @(posedge clk) disable iff (reset)
      exec ##1 irqMask[`CRF_EVT_DONE] |=> ##1 interrupt;
  endproperty
  a_irqFollows: assert property (p_irqFollows)
    else $error("unmasked compare event raised no interrupt");

  // Other half of each ordering flag: signed for less, less-or-equal, greater; unsigned for greater-or-equal
  property p_signedLess;
    @(posedge clk) disable iff (reset)
      s_execSigned |=>
        lessThanFlag == ($signed($past(chkA)) < $signed($past(chkB)));
  endproperty
  a_signedLess: assert property (p_signedLess) // see RL1
    else $error("less-than flag wrong after signed compare");

  property p_signedLessOrEqual;
    @(posedge clk) disable iff (reset)
      s_execSigned |=>
        lessOrEqualFlag == ($signed($past(chkA)) <= $signed($past(chkB)));
  endproperty
  a_signedLessOrEqual: assert property (p_signedLessOrEqual) // see RL2
    else $error("less-or-equal flag wrong after signed compare");

  property p_signedGreater;
    @(posedge clk) disable iff (reset)
      s_execSigned |=>
        greaterThanFlag == ($signed($past(chkA)) > $signed($past(chkB)));
  endproperty
  a_signedGreater: assert property (p_signedGreater) // see RL4
    else $error("greater-than flag wrong after signed compare");

  property p_unsignedGreaterOrEqual;
    @(posedge clk) disable iff (reset)
      s_execUnsigned |=> greaterOrEqualFlag == ($past(chkA) >= $past(chkB));
  endproperty
  a_unsignedGreaterOrEqual: assert property (p_unsignedGreaterOrEqual) // see RL5
    else $error("greater-or-equal flag wrong after unsigned compare");

  // Read data is zero outside the cycle after a read strobe
  property p_readIdle;
    @(posedge clk) disable iff (reset)
      !regRead |=> regRdata == '0;
  endproperty
  a_readIdle: assert property (p_readIdle)
    else $error("read data present with no read strobe");

  property p_operandRead;
    @(posedge clk) disable iff (reset)
      regRead && hit(regAddr, `CRF_ADDR_OPA) |=>
        regRdata == widen($past(state.opA));
  endproperty
  a_operandRead: assert property (p_operandRead)
    else $error("first operand register read back wrong");

  // A compare always leaves its status bit set, even beside a clear
  property p_statSticky;
    @(posedge clk) disable iff (reset)
      exec |=> irqStatus[`CRF_EVT_DONE];
  endproperty
  a_statSticky: assert property (p_statSticky)
    else $error("compare event did not set its status bit");

  // Interrupt trails the masked status by exactly two flops
  property p_irqLevel;
    @(posedge clk) disable iff (reset)
      1'b1 |-> interrupt == $past(irqPending, 2);
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("interrupt level does not follow masked status");

endmodule : crf_compare_flags

// ==== hw/crf_consts.svh ====
// Offsets, field positions, reset values for compare-result flags.
// Assumes inclusion by bare name from package and modules.
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH
`define CRF_ADDR_W 4
`define CRF_DATA_W 16
`define CRF_ADDR_OPA 4'h0
`define CRF_ADDR_OPB 4'h1
`define CRF_ADDR_CTRL 4'h2
`define CRF_ADDR_FLAGS 4'h3
`define CRF_ADDR_STAT 4'h4
`define CRF_ADDR_MASK 4'h5
`define CRF_CTRL_SIGNED 0
`define CRF_CTRL_GO 1
`define CRF_BIT_LESS 0
`define CRF_BIT_LE 1
`define CRF_BIT_EQ 2
`define CRF_BIT_GREATER 3
`define CRF_BIT_GE 4
`define CRF_BIT_NE 5
`define CRF_FLAG_CNT 6
`define CRF_EVT_DONE 0
`define CRF_EVT_CNT 1
`define CRF_FLAGS_RST 6'h00
`define CRF_MASK_RST 1'h0
`endif

// ==== hw/crf_irq_unit.sv ====
// Sticky event status, mask gate, level interrupt.
// Assumes one-cycle event pulses and one-cycle read-clear pulses.
`timescale 1ns/1ps
module crf_irq_unit #(
  parameter int N = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Events and software side
  input wire logic [N-1:0] eventIn,
  input wire logic readClear,
  input wire logic [N-1:0] mask,
  // Results
  output logic [N-1:0] status,
  output logic irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic irq;
  } crf_irq_state_t;
  crf_irq_state_t state;
  crf_irq_state_t next_state;
  // Set beats a clear in the same cycle so no event is lost
  always_comb begin
    next_state = state;
    if (readClear) begin
      next_state.status = '0;
    end
    next_state.status = next_state.status | eventIn;
    next_state.irq = |(state.status & mask);
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign status = state.status;
  assign irq = state.irq;
endmodule : crf_irq_unit

// ==== hw/crf_pkg.sv ====
// Types shared by the compare-result flag block.
// Assumes crf_consts.svh is on the include path.
`include "crf_consts.svh"
package crf_pkg;
  typedef logic [`CRF_FLAG_CNT-1:0] crf_flags_t;
  typedef logic [`CRF_ADDR_W-1:0] crf_addr_t;
  typedef logic [`CRF_DATA_W-1:0] crf_data_t;
endpackage : crf_pkg

// ==== tb/crf_compare_flags_test.sv ====
// Self-checking bench for the compare-result flag block.
// Assumes crf_consts.svh on the include path and crf_pkg compiled first.
`timescale 1ns/1ps
`include "crf_consts.svh"
module crf_compare_flags_test;
  import crf_pkg::*;
  // Clock, reset and stimulus
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic compareInstruction = 1'b0;
  logic [15:0] firstOperand = 16'h0000;
  logic [15:0] secondOperand = 16'h0000;
  crf_addr_t regAddr = 4'h0;
  crf_data_t regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  // Observed outputs
  crf_data_t regRdata;
  logic lessThanFlag, lessOrEqualFlag, equalFlag, greaterThanFlag;
  logic greaterOrEqualFlag, notEqualFlag, interrupt;
  crf_flags_t flagsOut;
  crf_data_t rd;
  crf_flags_t held;
  int nFail = 0;
  int numChecks = 0;
  int cycles = 0;
  logic [15:0] ta [6];
  logic [15:0] tb [6];

  // Flag outputs gathered in register bit order
  assign flagsOut = {notEqualFlag, greaterOrEqualFlag, greaterThanFlag,
                     equalFlag, lessOrEqualFlag, lessThanFlag};

  crf_compare_flags #(.W(16)) u_crf_compare_flags (
    .clk(clk), .reset(reset),
    .compareInstruction(compareInstruction),
    .firstOperand(firstOperand), .secondOperand(secondOperand),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata),
    .lessThanFlag(lessThanFlag), .lessOrEqualFlag(lessOrEqualFlag),
    .equalFlag(equalFlag), .greaterThanFlag(greaterThanFlag),
    .greaterOrEqualFlag(greaterOrEqualFlag), .notEqualFlag(notEqualFlag),
    .interrupt(interrupt)
  );

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Expected flags worked out independently of the design
  function automatic crf_flags_t expF(logic [15:0] a, logic [15:0] b, logic sg);
    logic lt;
    logic eq;
    lt = sg ? ($signed(a) < $signed(b)) : (a < b);
    eq = (a == b);
    return {!eq, !lt, !lt && !eq, eq, lt || eq, lt};
  endfunction : expF

  task automatic finishTest;
    $display("Checks %0d, mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finishTest

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkVal

  task automatic checkFlags(input crf_flags_t exp);
    numChecks++;
    if (flagsOut !== exp) begin
      nFail++;
      $display("Error t=%0t flags got=%h exp=%h", $time, flagsOut, exp);
    end
  endtask : checkFlags

  // One-cycle write strobe; returns just after the taking edge
  task automatic wrReg(input crf_addr_t a, input crf_data_t d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wrReg

  // Read data stands only in the cycle after the strobe
  task automatic rdReg(input crf_addr_t a, output crf_data_t d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rdReg

  // CPU compare pulse; flags checked in the following cycle
  task automatic compareExec(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    compareInstruction <= 1'b1;
    firstOperand <= a;
    secondOperand <= b;
    @(posedge clk);
    compareInstruction <= 1'b0;
    #1;
  endtask : compareExec

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      nFail++;
      finishTest();
    end
  end

  initial begin
    ta = '{16'h0000, 16'h0000, 16'hFFFF, 16'h1234, 16'h7FFF, 16'h8000};
    tb = '{16'h0000, 16'hFFFF, 16'h0000, 16'h1234, 16'h8000, 16'h7FFF};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1;
    checkFlags(6'h00);
    checkVal({15'h0000, interrupt}, 16'h0000);
    // Back-to-back compares, each result seen one cycle later
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      compareInstruction <= 1'b1;
      firstOperand <= ta[i];
      secondOperand <= tb[i];
      #1;
      if (i > 0) checkFlags(expF(ta[i-1], tb[i-1], 1'b0));
    end
    @(posedge clk);
    compareInstruction <= 1'b0;
    #1 checkFlags(expF(ta[5], tb[5], 1'b0));
    // Unused positions above the six flags read zero
    rdReg(`CRF_ADDR_FLAGS, rd);
    checkVal(rd, {10'h000, expF(ta[5], tb[5], 1'b0)});
    wrReg(`CRF_ADDR_FLAGS, 16'hFFFF);
    rdReg(`CRF_ADDR_FLAGS, rd);
    checkVal(rd, {10'h000, expF(ta[5], tb[5], 1'b0)});
    rdReg(4'hF, rd);
    checkVal(rd, 16'h0000);
    // Operand changes without a compare must not move the flags
    held = flagsOut;
    firstOperand <= 16'h0001;
    secondOperand <= 16'h0002;
    wrReg(`CRF_ADDR_OPA, 16'h0005);
    repeat (3) @(posedge clk);
    #1 checkFlags(held);
    // Signed mode, CPU port and register-started compare
    wrReg(`CRF_ADDR_CTRL, 16'h0001);
    compareExec(16'hFFFF, 16'h0001);
    checkFlags(expF(16'hFFFF, 16'h0001, 1'b1));
    wrReg(`CRF_ADDR_OPA, 16'h0002);
    wrReg(`CRF_ADDR_OPB, 16'hFFFE);
    wrReg(`CRF_ADDR_CTRL, 16'h0003);
    checkFlags(expF(16'h0002, 16'hFFFE, 1'b1));
    // Held registers read back; the go bit is write-only
    rdReg(`CRF_ADDR_OPA, rd);
    checkVal(rd, 16'h0002);
    rdReg(`CRF_ADDR_OPB, rd);
    checkVal(rd, 16'hFFFE);
    rdReg(`CRF_ADDR_CTRL, rd);
    checkVal(rd, 16'h0001);
    // Read data must not outlive its one cycle
    @(posedge clk);
    #1 checkVal(regRdata, 16'h0000);
    // CPU compare beside a register start: CPU operands win
    @(posedge clk);
    compareInstruction <= 1'b1;
    firstOperand <= 16'h0001;
    secondOperand <= 16'h0009;
    regWrite <= 1'b1;
    regAddr <= `CRF_ADDR_CTRL;
    regWdata <= 16'h0002;
    @(posedge clk);
    compareInstruction <= 1'b0;
    regWrite <= 1'b0;
    #1 checkFlags(expF(16'h0001, 16'h0009, 1'b0));
    compareExec(16'hFFFF, 16'h0001);
    checkFlags(expF(16'hFFFF, 16'h0001, 1'b0));
    // Masked event stays sticky, unmasking raises the interrupt
    rdReg(`CRF_ADDR_STAT, rd);
    rdReg(`CRF_ADDR_MASK, rd);
    checkVal(rd, 16'h0000);
    compareExec(16'h0003, 16'h0003);
    repeat (3) @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0000);
    wrReg(`CRF_ADDR_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0001);
    rdReg(`CRF_ADDR_STAT, rd);
    checkVal(rd, 16'h0001);
    // Interrupt falls two edges after the clearing read
    @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0001);
    @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0000);
    // Unmasked compare: interrupt two edges after the exec edge
    compareExec(16'h0004, 16'h0009);
    checkVal({15'h0000, interrupt}, 16'h0000);
    @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0000);
    @(posedge clk);
    #1 checkVal({15'h0000, interrupt}, 16'h0001);
    rdReg(`CRF_ADDR_STAT, rd);
    checkVal(rd, 16'h0001);
    rdReg(`CRF_ADDR_STAT, rd);
    checkVal(rd, 16'h0000);
    checkVal({15'h0000, interrupt}, 16'h0000);
    finishTest();
  end
endmodule : crf_compare_flags_test
